// ---- urms_pkg.sv ----
// Behaviour
// - divisor bytes at 0/1 when divisor bit, no key
// - upper enable/trigger/modem bits need enhanced enable
// - enable bits gate sources, pending shown in status
// - fifo mode: receive interrupt follows trigger level
// - status code and interrupt clear together below trigger
// - data ready set on push, clear when empty
// - status bit 1 flags receive overrun
// - bits 2-4 show head character errors
// - bit 5 holding empty, bit 6 all empty
// - bit 7 set if any stored character erred
// - non-fifo: receive interrupt when holding has data
// - status bit 0 high when nothing pending
package urms_pkg;
    // standard bank
    localparam logic [2:0] ADR_RX_HOLD     = 3'h0;
    localparam logic [2:0] ADR_INT_EN      = 3'h1;
    localparam logic [2:0] ADR_INT_STAT    = 3'h2;
    localparam logic [2:0] ADR_LINE_CTRL   = 3'h3;
    localparam logic [2:0] ADR_MODEM_CTRL  = 3'h4;
    localparam logic [2:0] ADR_LINE_STAT   = 3'h5;
    localparam logic [2:0] ADR_SCRATCH     = 3'h7;
    // divisor and enhanced banks
    localparam logic [2:0] ADR_DIV_LOW     = 3'h0;
    localparam logic [2:0] ADR_DIV_HIGH    = 3'h1;
    localparam logic [2:0] ADR_TRIG_COUNT  = 3'h0;
    localparam logic [2:0] ADR_FEATURE     = 3'h1;
    localparam logic [2:0] ADR_ENH_FUNC    = 3'h2;
    localparam logic [2:0] ADR_FLOW_BASE   = 3'h4;
    localparam logic [7:0] ENH_KEY         = 8'hBF;
    localparam int         LC_DIV_BIT      = 7;
    localparam int         EF_ENABLE_BIT   = 4;
    // interrupt enable bits
    localparam int         IE_RX           = 0;
    localparam int         IE_TX           = 1;
    localparam int         IE_LINE         = 2;
    localparam int         IE_MODEM        = 3;
    // fifo control bits
    localparam int         FF_EN           = 0;
    localparam int         FF_RX_RST       = 1;
    localparam int         FF_TX_RST       = 2;
    localparam int         FF_DMA          = 3;
    localparam int         FF_TX_TRIG      = 4;
    localparam int         FF_RX_TRIG      = 6;
    // status codes, low nibble
    localparam logic [3:0] IS_LINE         = 4'h6;
    localparam logic [3:0] IS_RX_DATA      = 4'h4;
    localparam logic [3:0] IS_TX_READY     = 4'h2;
    localparam logic [3:0] IS_MODEM        = 4'h0;
    localparam logic [3:0] IS_NONE         = 4'h1;
    // receive fifo shape
    localparam int         RX_DEPTH        = 64;
    localparam int         PTR_W           = 6;
    localparam int         CNT_W           = 7;
    localparam int         RX_W            = 11;
    localparam logic [6:0] RX_FULL_CNT     = 7'h40;
    // trigger table by fifo control bits 7:6; feature code 3 = programmed
    localparam logic [3:0][6:0] RX_TRIG_TABLE = {7'h3C, 7'h38, 7'h10, 7'h08};
    localparam int         FEAT_TRIG       = 4;
    localparam logic [1:0] FEAT_TRIG_PROG  = 2'h3;
    // identification, values arbitrary
    localparam logic [7:0] REVISION_CODE   = 8'h01;
    localparam logic [7:0] DEVICE_IDENT    = 8'h5C;
    localparam logic [7:0] REG_RST         = 8'h00;

    typedef enum logic [1:0] {
        URMS_BANK_STD = 2'b00,
        URMS_BANK_DIV = 2'b01,
        URMS_BANK_ENH = 2'b10
    } urms_bank_t;

    // bank selected by the line control value
    function automatic urms_bank_t urms_bank_of(input logic [7:0] lc);
        if (lc == ENH_KEY) begin
            return URMS_BANK_ENH;
        end else if (lc[LC_DIV_BIT]) begin
            return URMS_BANK_DIV;
        end
        return URMS_BANK_STD;
    endfunction
endpackage

// ---- urms_rx_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface urms_rx_if;
    logic                               push;
    logic [urms_pkg::RX_W-1:0]          push_data;
    logic                               pop;
    logic                               flush;
    logic [urms_pkg::RX_W-1:0]          head;
    logic [urms_pkg::CNT_W-1:0]         count;
    logic                               err_any;
    logic                               full;
    modport ctl  (output push, push_data, pop, flush, input head, count, err_any, full);
    modport fifo (input push, push_data, pop, flush, output head, count, err_any, full);
endinterface
`default_nettype wire

// ---- urms_rx_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module urms_rx_fifo (
    input  wire logic clk_i,
    input  wire logic rst_i,
    urms_rx_if.fifo   rx
);
    typedef struct packed {
        logic [urms_pkg::RX_DEPTH-1:0][urms_pkg::RX_W-1:0] mem;
        logic [urms_pkg::PTR_W-1:0]                       wr;
        logic [urms_pkg::PTR_W-1:0]                       rd;
        logic [urms_pkg::CNT_W-1:0]                       cnt;
        logic [urms_pkg::CNT_W-1:0]                       errs;
    } urms_fifo_st_t;

    urms_fifo_st_t q;
    urms_fifo_st_t d;
    logic          push_ok;
    logic          pop_ok;

    assign push_ok = rx.push & ~rx.full;
    assign pop_ok  = rx.pop & (q.cnt != '0);

    // errored characters are counted so the global flag needs no scan
    always_comb begin
        d = q;
        if (rx.flush) begin
            d.wr   = '0;
            d.rd   = '0;
            d.cnt  = '0;
            d.errs = '0;
        end else begin
            if (push_ok) begin
                d.mem[q.wr] = rx.push_data;
                d.wr        = q.wr + 6'h1;
            end
            if (pop_ok) begin
                d.rd = q.rd + 6'h1;
            end
            d.cnt  = q.cnt + {6'h00, push_ok} - {6'h00, pop_ok};
            d.errs = q.errs + {6'h00, push_ok & (|rx.push_data[10:8])}
                            - {6'h00, pop_ok & (|rx.head[10:8])};
        end
    end

    // memory left out of reset; contents read behind the count, except the holding read, which takes the head even at count zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q.wr   <= '0;
            q.rd   <= '0;
            q.cnt  <= '0;
            q.errs <= '0;
        end else begin
            q.wr   <= d.wr;
            q.rd   <= d.rd;
            q.cnt  <= d.cnt;
            q.errs <= d.errs;
        end
        q.mem <= d.mem;
    end

    assign rx.head    = q.mem[q.rd];
    assign rx.count   = q.cnt;
    assign rx.err_any = (q.errs != '0);
    assign rx.full    = (q.cnt == urms_pkg::RX_FULL_CNT);
endmodule
`default_nettype wire

// ---- urms_regmap.sv ----
`timescale 1ns/1ps
`default_nettype none
module urms_regmap (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_I,
    input  wire logic        CS_I,
    input  wire logic        RD_I,
    input  wire logic        WR_I,
    input  wire logic [2:0]  ADDR_I,
    input  wire logic [7:0]  WDATA_I,
    output logic      [7:0]  RDATA_O,
    output logic             INT_O,
    input  wire logic        RX_PUSH_I,
    input  wire logic [7:0]  RX_DATA_I,
    input  wire logic [2:0]  RX_ERR_I,
    input  wire logic        RX_OVERRUN_I,
    input  wire logic        TX_HOLD_EMPTY_I,
    input  wire logic        TX_SHIFT_EMPTY_I,
    input  wire logic        MODEM_DELTA_I,
    output logic             TX_WR_O,
    output logic      [7:0]  TX_DATA_O,
    output logic             TX_FIFO_RESET_O,
    output logic      [1:0]  TX_TRIG_O,
    output logic      [15:0] DIVISOR_O,
    output logic      [7:0]  LINE_CTRL_O,
    output logic      [7:0]  MODEM_CTRL_O,
    output logic             FIFO_EN_O
);
    typedef struct packed {
        logic [7:0]       line_ctrl;
        logic [7:0]       int_en;
        logic [7:0]       modem_ctrl;
        logic [7:0]       div_low;
        logic [7:0]       div_high;
        logic [7:0]       enh_func;
        logic [7:0]       feature;
        logic [7:0]       trig_prog;
        logic [7:0]       scratch;
        logic [3:0][7:0]  flow_char;
        logic             fifo_en;
        logic             dma_mode;
        logic [1:0]       rx_trig;
        logic [1:0]       tx_trig;
        logic             overrun;
        logic             tx_ready;
        logic             tx_empty_prev;
        logic [7:0]       rdata;
        logic [7:0]       tx_data;
        logic             tx_wr;
        logic             tx_rst;
    } urms_state_t;

    urms_state_t          q;
    urms_state_t          d;
    urms_rx_if            rx ();
    urms_pkg::urms_bank_t bank;
    logic                 rd_take;
    logic                 wr_take;
    logic                 enh_on;
    logic [7:0]           ie_eff;
    logic [7:0]           line_stat;
    logic [7:0]           int_stat;
    logic [2:0]           head_err;
    logic                 rx_nonempty;
    logic                 rx_at_trig;
    logic [6:0]           trig_lvl;
    logic                 div_zero;
    logic                 src_line;
    logic                 src_rx;
    logic                 src_tx;
    logic                 src_modem;
    logic                 pending;

    urms_rx_fifo u_rx_fifo (
        .clk_i (CLK_SYS_I),
        .rst_i (RST_I),
        .rx    (rx.fifo)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode; host bus runs on the system clock, so no synchroniser
    assign bank     = urms_pkg::urms_bank_of(q.line_ctrl);
    assign rd_take  = CS_I & RD_I;
    assign wr_take  = CS_I & WR_I;
    assign enh_on   = q.enh_func[urms_pkg::EF_ENABLE_BIT];
    assign div_zero = (q.div_low == 8'h00) && (q.div_high == 8'h00);

    // upper enables are dead weight until the enhanced bit is set
    assign ie_eff = {enh_on ? q.int_en[7:4] : 4'h0, q.int_en[3:0]};

    ////////////////////////////////////////////////////////////////////////
    // receive fifo hookup
    assign rx.push      = RX_PUSH_I;
    assign rx.push_data = {RX_ERR_I, RX_DATA_I};
    assign rx.pop       = rd_take && bank == urms_pkg::URMS_BANK_STD
                          && ADDR_I == urms_pkg::ADR_RX_HOLD;
    assign rx.flush     = wr_take && bank != urms_pkg::URMS_BANK_ENH
                          && ADDR_I == urms_pkg::ADR_INT_STAT
                          && WDATA_I[urms_pkg::FF_EN] && WDATA_I[urms_pkg::FF_RX_RST];

    assign rx_nonempty = (rx.count != '0);
    assign head_err    = rx_nonempty ? rx.head[10:8] : 3'h0;

    // programmed level only when the feature table code asks for it
    assign trig_lvl = (q.feature[urms_pkg::FEAT_TRIG +: 2] == urms_pkg::FEAT_TRIG_PROG)
                      ? q.trig_prog[6:0] : urms_pkg::RX_TRIG_TABLE[q.rx_trig];
    assign rx_at_trig = rx_nonempty && (rx.count >= trig_lvl);

    ////////////////////////////////////////////////////////////////////////
    // line status view
    assign line_stat = {rx.err_any,
                        TX_HOLD_EMPTY_I & TX_SHIFT_EMPTY_I,
                        TX_HOLD_EMPTY_I,
                        head_err,
                        q.overrun,
                        rx_nonempty};

    ////////////////////////////////////////////////////////////////////////
    // interrupt sources, gated by the enables
    assign src_line  = ie_eff[urms_pkg::IE_LINE] & (q.overrun | (|head_err));
    assign src_rx    = ie_eff[urms_pkg::IE_RX]
                       & (q.fifo_en ? rx_at_trig : rx_nonempty);
    assign src_tx    = ie_eff[urms_pkg::IE_TX] & q.tx_ready;
    assign src_modem = ie_eff[urms_pkg::IE_MODEM] & MODEM_DELTA_I;
    assign pending   = src_line | src_rx | src_tx | src_modem;

    // highest source wins; code and output fall in the same cycle
    assign int_stat[7:6] = {2{q.fifo_en}};
    assign int_stat[5:4] = 2'h0; // xoff and flow sources live outside
    assign int_stat[3:0] = src_line  ? urms_pkg::IS_LINE :
                           src_rx    ? urms_pkg::IS_RX_DATA :
                           src_tx    ? urms_pkg::IS_TX_READY :
                           src_modem ? urms_pkg::IS_MODEM :
                                       urms_pkg::IS_NONE;
    assign INT_O = pending;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        d               = q;
        d.tx_wr         = 1'b0;
        d.tx_rst        = 1'b0;
        d.tx_empty_prev = TX_HOLD_EMPTY_I;
        // set wins over the read that clears it
        d.overrun = (q.overrun & ~(rd_take && bank != urms_pkg::URMS_BANK_ENH
                                   && ADDR_I == urms_pkg::ADR_LINE_STAT))
                    | RX_OVERRUN_I | (RX_PUSH_I & rx.full);
        if (rd_take && bank != urms_pkg::URMS_BANK_ENH && ADDR_I == urms_pkg::ADR_INT_STAT) begin
            d.tx_ready = 1'b0;
        end
        // writes
        if (wr_take) begin
            unique case (bank)
                urms_pkg::URMS_BANK_ENH: begin
                    if (ADDR_I == urms_pkg::ADR_TRIG_COUNT) begin
                        d.trig_prog = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_FEATURE) begin
                        d.feature = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_ENH_FUNC) begin
                        d.enh_func = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_LINE_CTRL) begin
                        d.line_ctrl = WDATA_I;
                    end else if (ADDR_I[2]) begin
                        d.flow_char[ADDR_I[1:0]] = WDATA_I;
                    end
                end
                urms_pkg::URMS_BANK_DIV, urms_pkg::URMS_BANK_STD: begin
                    if (bank == urms_pkg::URMS_BANK_DIV && ADDR_I == urms_pkg::ADR_DIV_LOW) begin
                        d.div_low = WDATA_I;
                    end else if (bank == urms_pkg::URMS_BANK_DIV && ADDR_I == urms_pkg::ADR_DIV_HIGH) begin
                        d.div_high = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_RX_HOLD) begin
                        d.tx_data  = WDATA_I;
                        d.tx_wr    = 1'b1;
                        d.tx_ready = 1'b0;
                    end else if (ADDR_I == urms_pkg::ADR_INT_EN) begin
                        d.int_en = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_INT_STAT) begin
                        // other bits only take with the enable bit set
                        d.fifo_en = WDATA_I[urms_pkg::FF_EN];
                        if (WDATA_I[urms_pkg::FF_EN]) begin
                            d.dma_mode = WDATA_I[urms_pkg::FF_DMA];
                            d.rx_trig  = WDATA_I[urms_pkg::FF_RX_TRIG +: 2];
                            d.tx_rst   = WDATA_I[urms_pkg::FF_TX_RST];
                            if (enh_on) begin
                                d.tx_trig = WDATA_I[urms_pkg::FF_TX_TRIG +: 2];
                            end
                        end
                    end else if (ADDR_I == urms_pkg::ADR_LINE_CTRL) begin
                        d.line_ctrl = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_MODEM_CTRL) begin
                        d.modem_ctrl = WDATA_I;
                    end else if (ADDR_I == urms_pkg::ADR_SCRATCH) begin
                        d.scratch = WDATA_I;
                    end
                end
                default: begin
                end
            endcase
        end
        // transmit-ready event: empty edge, or enable while already empty
        if ((TX_HOLD_EMPTY_I & ~q.tx_empty_prev)
            || (wr_take && bank == urms_pkg::URMS_BANK_STD && ADDR_I == urms_pkg::ADR_INT_EN
                && WDATA_I[urms_pkg::IE_TX] && TX_HOLD_EMPTY_I)) begin
            d.tx_ready = 1'b1;
        end
        // reads: data captured on the taking edge
        if (rd_take) begin
            d.rdata = 8'h00;
            unique case (ADDR_I)
                3'h0: begin
                    if (bank == urms_pkg::URMS_BANK_ENH) begin
                        d.rdata = {1'b0, rx.count};
                    end else if (bank == urms_pkg::URMS_BANK_DIV) begin
                        d.rdata = div_zero ? urms_pkg::REVISION_CODE : q.div_low;
                    end else begin
                        d.rdata = rx.head[7:0];
                    end
                end
                3'h1: begin
                    if (bank == urms_pkg::URMS_BANK_ENH) begin
                        d.rdata = q.feature;
                    end else if (bank == urms_pkg::URMS_BANK_DIV) begin
                        d.rdata = div_zero ? urms_pkg::DEVICE_IDENT : q.div_high;
                    end else begin
                        d.rdata = ie_eff;
                    end
                end
                3'h2: d.rdata = (bank == urms_pkg::URMS_BANK_ENH) ? q.enh_func : int_stat;
                3'h3: d.rdata = q.line_ctrl;
                3'h4: d.rdata = (bank == urms_pkg::URMS_BANK_ENH) ? q.flow_char[0] : MODEM_CTRL_O;
                3'h5: d.rdata = (bank == urms_pkg::URMS_BANK_ENH) ? q.flow_char[1] : line_stat;
                3'h6: d.rdata = (bank == urms_pkg::URMS_BANK_ENH) ? q.flow_char[2] : 8'h00;
                3'h7: d.rdata = (bank == urms_pkg::URMS_BANK_ENH) ? q.flow_char[3] : q.scratch;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            q <= '0;
            q.line_ctrl <= urms_pkg::REG_RST;
            // idle transmitter reads empty, so no false ready edge after reset
            q.tx_empty_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign RDATA_O         = q.rdata;
    assign TX_WR_O         = q.tx_wr;
    assign TX_DATA_O       = q.tx_data;
    assign TX_FIFO_RESET_O = q.tx_rst;
    assign TX_TRIG_O       = enh_on ? q.tx_trig : 2'h0;
    assign DIVISOR_O       = {q.div_high, q.div_low};
    assign LINE_CTRL_O     = q.line_ctrl;
    assign MODEM_CTRL_O    = {enh_on ? q.modem_ctrl[7:5] : 3'h0, q.modem_ctrl[4:0]};
    assign FIFO_EN_O       = q.fifo_en;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);

    logic rd_line_stat;
    logic rd_int_stat;
    assign rd_line_stat = rd_take && bank == urms_pkg::URMS_BANK_STD && ADDR_I == urms_pkg::ADR_LINE_STAT;
    assign rd_int_stat  = rd_take && bank == urms_pkg::URMS_BANK_STD && ADDR_I == urms_pkg::ADR_INT_STAT;

    a_div_low_read: assert property (
        rd_take && bank == urms_pkg::URMS_BANK_DIV && ADDR_I == 3'h0 && !div_zero
        |=> RDATA_O == $past(q.div_low)) else $error("divisor low byte not returned");
    a_upper_enable_mask: assert property (
        rd_take && bank == urms_pkg::URMS_BANK_STD && ADDR_I == 3'h1 && !enh_on
        |=> RDATA_O[7:4] == 4'h0) else $error("upper enables visible without enhanced bit");
    a_enabled_src_int: assert property (
        src_line || src_tx |-> INT_O && int_stat[0] == 1'b0) else $error("enabled source not reported");
    a_rx_level_int: assert property (
        q.fifo_en && ie_eff[0] && rx_at_trig |-> INT_O) else $error("trigger level reached, no interrupt");
    a_rx_level_drop: assert property (
        q.fifo_en && !rx_at_trig && !src_line && !src_tx && !src_modem
        |-> !INT_O && int_stat[3:0] == 4'h1) else $error("below trigger, interrupt still up");
    a_ready_bit: assert property (
        rd_line_stat |=> RDATA_O[0] == ($past(rx.count) != 7'h00)) else $error("data ready bit wrong");
    a_overrun_shown: assert property (
        RX_OVERRUN_I ##1 !(rd_take && ADDR_I == urms_pkg::ADR_LINE_STAT) ##1 rd_line_stat
        |=> RDATA_O[1]) else $error("overrun not shown");
    a_head_errors: assert property (
        rd_line_stat && rx_nonempty |=> RDATA_O[4:2] == $past(rx.head[10:8])) else $error("head error bits wrong");
    a_tx_empty_bits: assert property (
        rd_line_stat |=> RDATA_O[6:5] == $past({TX_HOLD_EMPTY_I & TX_SHIFT_EMPTY_I, TX_HOLD_EMPTY_I}))
        else $error("transmit empty bits wrong");
    a_global_error: assert property (
        RX_PUSH_I && !rx.full && RX_ERR_I != 3'h0 && !rx.flush |=> rx.err_any) else $error("error char not flagged");
    a_nonfifo_rx_int: assert property (
        !q.fifo_en && ie_eff[0] && rx_nonempty |-> INT_O) else $error("holding data, no interrupt");
    a_idle_code: assert property (
        rd_int_stat && !pending |=> RDATA_O[3:0] == 4'h1) else $error("idle status code wrong");
    a_enh_bank_map: assert property (
        wr_take && bank == urms_pkg::URMS_BANK_ENH && ADDR_I == 3'h4
        ##1 !wr_take ##1 rd_take && !wr_take && bank == urms_pkg::URMS_BANK_ENH && ADDR_I == 3'h4
        |=> RDATA_O == $past(WDATA_I, 3)) else $error("flow char not mapped");
    a_ident_read: assert property (
        rd_take && bank == urms_pkg::URMS_BANK_DIV && ADDR_I == 3'h1 && div_zero
        |=> RDATA_O == urms_pkg::DEVICE_IDENT) else $error("ident byte not returned");

    c_rx_trigger: cover property (q.fifo_en && src_rx ##[1:40] !src_rx);
    c_overrun: cover property (rx.full && RX_PUSH_I);
    c_enh_bank: cover property (wr_take && bank == urms_pkg::URMS_BANK_ENH);
    c_ident: cover property (rd_take && bank == urms_pkg::URMS_BANK_DIV && div_zero);
endmodule
`default_nettype wire

// ---- urms_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module urms_host_model (
    input  wire logic       clk_i,
    output logic            cs_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic      [2:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial {cs_o, rd_o, wr_o, addr_o, wdata_o} = '0;
    // one access, held over exactly its taking edge; released data is inverted so stale values never match
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {cs_o, rd_o, wr_o, addr_o, wdata_o} <= {1'b1, ~w, w, a, d};
        @(posedge clk_i);
        {cs_o, rd_o, wr_o, addr_o, wdata_o} <= {3'h0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// ---- uart_register_map_status_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_register_map_status_tb;
    logic       clk = 1'b0, rst = 1'b1, cs, rd, wr, push = 1'b0, ovr = 1'b0, int_o;
    logic [2:0] addr, err = 3'h0;
    logic [7:0] wdata, rdata, rxd = 8'h00;
    logic       thr_e = 1'b1, tsr_e = 1'b0, twr_o, trst_o, fen_o;
    logic [1:0] ttrig_o;
    logic [7:0] tdata_o, lc_o;
    logic [15:0] div_o;
    int         miscompares = 0, cmp_count = 0;
    typedef struct {logic [7:0] lc; logic [2:0] a; logic [7:0] d, e;} urms_row_t;
    // bank select, write, read back; upper modem bits masked until the enhanced bit is on
    urms_row_t  rows[12] = '{'{8'h80, 3'h0, 8'h12, 8'h12}, '{8'h80, 3'h1, 8'h34, 8'h34},
        '{8'h03, 3'h7, 8'h5A, 8'h5A}, '{8'h00, 3'h4, 8'hE3, 8'h03}, '{8'hBF, 3'h2, 8'h10, 8'h10},
        '{8'hBF, 3'h4, 8'hA1, 8'hA1}, '{8'hBF, 3'h5, 8'hA2, 8'hA2}, '{8'hBF, 3'h6, 8'hA3, 8'hA3},
        '{8'hBF, 3'h7, 8'hA4, 8'hA4}, '{8'h00, 3'h4, 8'hE3, 8'hE3}, '{8'hBF, 3'h2, 8'h00, 8'h00},
        '{8'h00, 3'h1, 8'hF0, 8'h00}};
    always #5 clk = ~clk;
    urms_host_model i_host (.clk_i(clk), .cs_o(cs), .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
    urms_regmap i_dut (.CLK_SYS_I(clk), .RST_I(rst), .CS_I(cs), .RD_I(rd), .WR_I(wr), .ADDR_I(addr),
        .WDATA_I(wdata), .RDATA_O(rdata), .INT_O(int_o), .RX_PUSH_I(push), .RX_DATA_I(rxd),
        .RX_ERR_I(err), .RX_OVERRUN_I(ovr), .TX_HOLD_EMPTY_I(thr_e), .TX_SHIFT_EMPTY_I(tsr_e),
        .MODEM_DELTA_I(1'b0), .TX_WR_O(twr_o), .TX_DATA_O(tdata_o), .TX_FIFO_RESET_O(trst_o),
        .TX_TRIG_O(ttrig_o), .DIVISOR_O(div_o), .LINE_CTRL_O(lc_o), .MODEM_CTRL_O(), .FIFO_EN_O(fen_o));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic w(input logic [2:0] a, input logic [7:0] d);
        i_host.acc(1'b1, a, d);
    endtask
    // read data is registered at the taking edge, so look just after it
    task automatic rdc(input string n, input logic [2:0] a, input logic [7:0] e);
        i_host.acc(1'b0, a, 8'h00);
        #1 chk(n, e, rdata);
    endtask
    task automatic rx(input logic [7:0] d, input logic [2:0] e, input logic o);
        @(posedge clk);
        {push, rxd, err, ovr} <= {1'b1, d, e, o};
        @(posedge clk);
        {push, rxd, err, ovr} <= {1'b0, ~d, ~e, 1'b0};
        #1;
    endtask
    task automatic summarize();
        $display("compares %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // hang guard, far beyond the roughly 150 cycles the tests need
    initial begin
        #50000;
        miscompares++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rdc("status idle", 3'h2, 8'h01);
        rdc("line idle", 3'h5, 8'h20);
        foreach (rows[i]) begin
            w(3'h3, rows[i].lc);
            w(rows[i].a, rows[i].d);
            rdc("row", rows[i].a, rows[i].e);
        end
        chk("divisor high", 8'h34, div_o[15:8]);
        chk("divisor low", 8'h12, div_o[7:0]);
        // zeroed divisor exposes the identification bytes
        w(3'h3, 8'h80);
        w(3'h0, 8'h00);
        w(3'h1, 8'h00);
        rdc("revision", 3'h0, urms_pkg::REVISION_CODE);
        rdc("ident", 3'h1, urms_pkg::DEVICE_IDENT);
        chk("line ctrl", 8'h80, lc_o);
        // non-fifo: one char raises the receive interrupt
        w(3'h3, 8'h00);
        w(3'h1, 8'h01);
        rx(8'h3C, 3'h0, 1'b0);
        chk("int one", 8'h01, {7'h00, int_o});
        rdc("status rx", 3'h2, 8'h04);
        rdc("line ready", 3'h5, 8'h21);
        rdc("holding", 3'h0, 8'h3C);
        chk("int pop", 8'h00, {7'h00, int_o});
        rdc("line empty", 3'h5, 8'h20);
        // fifo mode, trigger of 8: seven stay quiet, the eighth fires
        // transmit trigger bits must not take while the enhanced bit is off
        w(3'h2, 8'h31);
        #1 chk("fifo ctrl", 8'h04, {5'h00, fen_o, ttrig_o});
        repeat (7) rx(8'h11, 3'h0, 1'b0);
        chk("int below", 8'h00, {7'h00, int_o});
        rx(8'h11, 3'h0, 1'b0);
        chk("int trig", 8'h01, {7'h00, int_o});
        rdc("status trig", 3'h2, 8'hC4);
        rdc("pop", 3'h0, 8'h11);
        chk("int drop", 8'h00, {7'h00, int_o});
        rdc("status drop", 3'h2, 8'hC1);
        // polled mode: enables off, fifo flushed, errored char plus overrun
        w(3'h1, 8'h00);
        w(3'h2, 8'h07);
        #1 chk("tx reset", 8'h01, {7'h00, trst_o});
        rx(8'h55, 3'h1, 1'b1);
        rdc("line err", 3'h5, 8'hA7);
        rdc("line reread", 3'h5, 8'hA5);
        rdc("pop err", 3'h0, 8'h55);
        rdc("line clear", 3'h5, 8'h20);
        @(posedge clk) tsr_e <= 1'b1;
        rdc("line all empty", 3'h5, 8'h60);
        // ready source: enable while empty, holding write drops it, empty edge raises it again
        w(3'h1, 8'h02);
        #1 chk("int tx", 8'h01, {7'h00, int_o});
        w(3'h0, 8'h77);
        #1 chk("tx write", 8'h77, twr_o ? tdata_o : 8'h00);
        chk("int tx write", 8'h00, {7'h00, int_o});
        @(posedge clk) thr_e <= 1'b0;
        @(posedge clk) thr_e <= 1'b1;
        rdc("status tx", 3'h2, 8'hC2);
        chk("int tx read", 8'h00, {7'h00, int_o});
        summarize();
    end
endmodule
`default_nettype wire
